// ===== rtl/scfp_pkg.sv
// Purpose: Shared constants and types of the serial configuration and
//          transmit queue port.
// Assumes: Serial link runs in clock-low-idle, sample-on-rise fashion.
// Notes:   Strobe codes and link period are plain defaults.
package scfp_pkg;

  // ----------------------------------------------------------------
  // Clocking
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 100;
  localparam int SCLK_PERIOD_NS = 800;

  // ----------------------------------------------------------------
  // Header byte layout
  // ----------------------------------------------------------------
  localparam int HDR_RW_BIT    = 7;
  localparam int HDR_BURST_BIT = 6;
  localparam int ADDR_W        = 6;
  localparam int BYTE_W        = 8;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [5:0] STROBE_LO_ADDR = 6'h30;
  localparam logic [5:0] STROBE_HI_ADDR = 6'h3D;
  localparam logic [5:0] TXQ_PORT_ADDR  = 6'h3F;

  // Strobe codes within the strobe range
  localparam logic [5:0] FLUSH_TX_CODE   = 6'h3B;
  localparam logic [5:0] POWER_DOWN_CODE = 6'h39;
  localparam logic [5:0] OSC_OFF_CODE    = 6'h32;

  // ----------------------------------------------------------------
  // Status byte layout
  // ----------------------------------------------------------------
  localparam int         STAT_READY_BIT  = 7;
  localparam int         STAT_STATE_MSB  = 6;
  localparam int         STAT_STATE_LSB  = 4;
  localparam int         STAT_FREE_MSB   = 3;
  localparam logic [2:0] STATE_IDLE      = 3'h0;
  localparam logic [2:0] STATE_UNDERRUN  = 3'h7;
  localparam logic [3:0] FREE_SATURATE   = 4'hF;

  // ----------------------------------------------------------------
  // Transmit queue
  // ----------------------------------------------------------------
  localparam int TXQ_DEPTH = 64;

  // ----------------------------------------------------------------
  // Header decoder states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    DEC_HDR  = 4'b0001,
    DEC_WR   = 4'b0010,
    DEC_RD   = 4'b0100,
    DEC_FIFO = 4'b1000
  } scfp_dec_t;

endpackage

// ===== rtl/scfp_sync.sv
// Purpose: Two-flop synchroniser for a group of independent levels.
// Assumes: Each bit is a level; no bus coherence across bits.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ns
module scfp_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         clock_i,
  input  wire logic         srst_i,
  // Levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic meta_r;
      logic hold_r;
      always_ff @(posedge clock_i) begin
        if (srst_i) begin
          meta_r <= RST_VAL[g];
          hold_r <= RST_VAL[g];
        end else begin
          meta_r <= async_i[g];
          hold_r <= meta_r;
        end
      end
      assign sync_o[g] = hold_r;
    end
  endgenerate

endmodule

// ===== rtl/scfp_skid.sv
// Purpose: Two-entry valid/ready buffer with registered outputs.
// Assumes: Single clock domain.
// Notes:   in_ready is low only while the spare entry is taken.
`timescale 1ns/1ns
module scfp_skid #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clock_i,
  input  wire logic         srst_i,
  // Fill side
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  // Drain side
  output logic              out_valid_o,
  output logic      [W-1:0] out_data_o,
  input  wire logic         out_ready_i
);

  logic         out_v_r;
  logic         out_v_nxt;
  logic [W-1:0] out_d_r;
  logic [W-1:0] out_d_nxt;
  logic         spr_v_r;
  logic         spr_v_nxt;
  logic [W-1:0] spr_d_r;
  logic [W-1:0] spr_d_nxt;
  logic         take;
  logic         give;

  always_comb begin
    out_v_nxt = out_v_r;
    out_d_nxt = out_d_r;
    spr_v_nxt = spr_v_r;
    spr_d_nxt = spr_d_r;
    take      = in_valid_i & ~spr_v_r;
    give      = out_v_r & out_ready_i;
    if (give) begin
      if (spr_v_r) begin
        out_d_nxt = spr_d_r;
        spr_v_nxt = 1'b0;
      end else if (take) begin
        out_d_nxt = in_data_i;
      end else begin
        out_v_nxt = 1'b0;
      end
    end else if (take) begin
      if (!out_v_r) begin
        out_d_nxt = in_data_i;
        out_v_nxt = 1'b1;
      end else begin
        spr_d_nxt = in_data_i;
        spr_v_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      out_v_r <= 1'b0;
      out_d_r <= '0;
      spr_v_r <= 1'b0;
      spr_d_r <= '0;
    end else begin
      out_v_r <= out_v_nxt;
      out_d_r <= out_d_nxt;
      spr_v_r <= spr_v_nxt;
      spr_d_r <= spr_d_nxt;
    end
  end

  assign in_ready_o  = ~spr_v_r;
  assign out_valid_o = out_v_r;
  assign out_data_o  = out_d_r;

endmodule

// ===== rtl/scfp_port.sv
// Purpose: Serial slave port: header decode, register access, strobes,
//          status byte and the transmit queue.
// Assumes: Serial clock idles low, data sampled on its rising edge and
//          changed on its falling edge; link clock at most 1/8 of clock_i.
// Notes:   Behaviour
// Behaviour
// - Bytes shift most significant bit first.
// - Chip select rising aborts any transfer.
// - Serial output low once ready after select.
// - Status byte returned during header.
// - Status bit7 is active-low ready flag.
// - Status bits 6:4 show main state.
// - Idle 000, underrun 111, flush clears.
// - Bits 3:0 free count, saturate 15.
// - Low registers read or written by flag.
// - Status returned with each written byte.
// - Burst address counts per byte until deselect.
// - Read/write flag selects status read or strobe.
// - Strobe is lone header, flags zero.
// - Any transaction may follow a strobe.
// - Power-down, oscillator-off strobes wait for deselect.
// - Queue at 0x3F, write only, 64 bytes.
// - 0x3F single byte, 0x7F until deselect.
// - Status shows free count before storing.
// - Queue emptied by flush or sleep entry.
`timescale 1ns/1ns
module scfp_port #(
  parameter int DEPTH = scfp_pkg::TXQ_DEPTH
) (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       srst_i,
  // Serial pins
  input  wire logic       sclk_i,
  input  wire logic       serial_in_i,
  input  wire logic       chip_select_low_i,
  output logic            serial_out_o,
  output logic            serial_out_oe_o,
  // Chip status
  input  wire logic       osc_stable_i,
  input  wire logic [2:0] main_state_i,
  input  wire logic       underflow_i,
  input  wire logic       sleep_enter_i,
  // Register file access
  output logic      [5:0] cfg_addr_o,
  output logic      [7:0] cfg_wdata_o,
  output logic            cfg_we_o,
  output logic            cfg_re_o,
  input  wire logic [7:0] cfg_rdata_i,
  // Command strobes
  output logic            strobe_valid_o,
  output logic      [5:0] strobe_code_o,
  // Transmit data
  output logic            tx_valid_o,
  output logic      [7:0] tx_data_o,
  input  wire logic       tx_ready_i
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = PTR_W + 1;
  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] SAT_C   = CNT_W'(scfp_pkg::FREE_SATURATE);

  generate
    if (DEPTH < 16 || (1 << PTR_W) != DEPTH) begin : g_chk
      $error("DEPTH must be a power of two of at least 16");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic sclk_s;
  logic mosi_s;
  logic csn_s;
  logic stable_s;

  scfp_sync #(
    .W       (4),
    .RST_VAL (4'h2)
  ) u_sync (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .async_i ({sclk_i, serial_in_i, chip_select_low_i, osc_stable_i}),
    .sync_o  ({sclk_s, mosi_s, csn_s, stable_s})
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]       mem [DEPTH];
  scfp_pkg::scfp_dec_t dec_r;
  scfp_pkg::scfp_dec_t dec_nxt;
  logic             sclk_d_r;
  logic             csn_d_r;
  logic [5:0]       addr_r;
  logic [5:0]       addr_nxt;
  logic             burst_r;
  logic             burst_nxt;
  logic [2:0]       bit_r;
  logic [2:0]       bit_nxt;
  logic [7:0]       in_r;
  logic [7:0]       in_nxt;
  logic [7:0]       out_r;
  logic [7:0]       out_nxt;
  logic             load_r;
  logic             load_nxt;
  logic             first_r;
  logic             first_nxt;
  logic             so_r;
  logic             so_nxt;
  logic             oe_r;
  logic             oe_nxt;
  logic [5:0]       cfg_addr_r;
  logic [5:0]       cfg_addr_nxt;
  logic [7:0]       cfg_wdata_r;
  logic [7:0]       cfg_wdata_nxt;
  logic             cfg_we_r;
  logic             cfg_we_nxt;
  logic             cfg_re_r;
  logic             cfg_re_nxt;
  logic             stb_v_r;
  logic             stb_v_nxt;
  logic [5:0]       stb_c_r;
  logic [5:0]       stb_c_nxt;
  logic             pend_pd_r;
  logic             pend_pd_nxt;
  logic             pend_xo_r;
  logic             pend_xo_nxt;
  logic             under_r;
  logic             under_nxt;
  logic [PTR_W-1:0] wptr_r;
  logic [PTR_W-1:0] wptr_nxt;
  logic [PTR_W-1:0] rptr_r;
  logic [PTR_W-1:0] rptr_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  // ----------------------------------------------------------------
  // Combinational helpers
  // ----------------------------------------------------------------
  logic             rise;
  logic             fall;
  logic             cs_rise;
  logic [7:0]       byte_in;
  logic [CNT_W-1:0] free_cnt;
  logic [3:0]       free4;
  logic [2:0]       state_fld;
  logic [7:0]       status;
  logic             push;
  logic             pop;
  logic             flush;
  logic             skid_ready;
  logic [5:0]       hdr_a;
  logic             hdr_rw;
  logic             hdr_b;

  assign rise    = sclk_s & ~sclk_d_r;
  assign fall    = ~sclk_s & sclk_d_r;
  assign cs_rise = csn_s & ~csn_d_r;
  assign byte_in = {in_r[6:0], mosi_s};
  assign hdr_a   = byte_in[scfp_pkg::ADDR_W-1:0];
  assign hdr_rw  = byte_in[scfp_pkg::HDR_RW_BIT];
  assign hdr_b   = byte_in[scfp_pkg::HDR_BURST_BIT];

  // Free count taken from the queue before the byte in flight lands
  assign free_cnt  = DEPTH_C - cnt_r;
  assign free4     = (free_cnt >= SAT_C) ? scfp_pkg::FREE_SATURATE
                                         : free_cnt[3:0];
  assign state_fld = under_r ? scfp_pkg::STATE_UNDERRUN
                             : main_state_i;
  assign status    = {~stable_s, state_fld, free4};
  assign pop       = (cnt_r != '0) & skid_ready;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    dec_nxt       = dec_r;
    addr_nxt      = addr_r;
    burst_nxt     = burst_r;
    bit_nxt       = bit_r;
    in_nxt        = in_r;
    out_nxt       = out_r;
    load_nxt      = load_r;
    first_nxt     = first_r;
    oe_nxt        = oe_r;
    cfg_addr_nxt  = cfg_addr_r;
    cfg_wdata_nxt = cfg_wdata_r;
    cfg_we_nxt    = 1'b0;
    cfg_re_nxt    = 1'b0;
    stb_v_nxt     = 1'b0;
    stb_c_nxt     = stb_c_r;
    pend_pd_nxt   = pend_pd_r;
    pend_xo_nxt   = pend_xo_r;
    push          = 1'b0;
    flush         = sleep_enter_i;
    if (csn_s) begin
      // Partial bytes are dropped and decoding restarts on a header
      dec_nxt   = scfp_pkg::DEC_HDR;
      burst_nxt = 1'b0;
      bit_nxt   = '0;
      load_nxt  = 1'b0;
      first_nxt = 1'b1;
      oe_nxt    = 1'b0;
      if (cs_rise && (pend_pd_r || pend_xo_r)) begin
        stb_v_nxt   = 1'b1;
        stb_c_nxt   = pend_pd_r ? scfp_pkg::POWER_DOWN_CODE
                                : scfp_pkg::OSC_OFF_CODE;
        pend_pd_nxt = 1'b0;
        pend_xo_nxt = pend_pd_r & pend_xo_r;
      end else if (pend_xo_r) begin
        stb_v_nxt   = 1'b1;
        stb_c_nxt   = scfp_pkg::OSC_OFF_CODE;
        pend_xo_nxt = 1'b0;
      end
    end else begin
      oe_nxt = 1'b1;
      // Ready flag tracks live until the first edge of the header
      if (first_r) begin
        out_nxt = status;
      end
      if (fall) begin
        out_nxt  = load_r ? ((dec_r == scfp_pkg::DEC_RD) ? cfg_rdata_i
                                                         : status)
                          : {out_r[6:0], 1'b0};
        load_nxt = 1'b0;
      end
      if (rise) begin
        first_nxt = 1'b0;
        in_nxt    = byte_in;
        bit_nxt   = bit_r + 3'h1;
        if (bit_r == 3'h7) begin
          load_nxt = 1'b1;
          case (dec_r)
            scfp_pkg::DEC_HDR: begin
              addr_nxt  = hdr_a;
              burst_nxt = hdr_b;
              if (!hdr_rw && hdr_a == scfp_pkg::TXQ_PORT_ADDR) begin
                dec_nxt = scfp_pkg::DEC_FIFO;
              end else if (hdr_a >= scfp_pkg::STROBE_LO_ADDR &&
                           hdr_a <= scfp_pkg::STROBE_HI_ADDR) begin
                if (hdr_rw) begin
                  // Status registers never burst
                  dec_nxt      = scfp_pkg::DEC_RD;
                  burst_nxt    = 1'b0;
                  cfg_addr_nxt = hdr_a;
                  cfg_re_nxt   = 1'b1;
                end else if (!hdr_b) begin
                  dec_nxt = scfp_pkg::DEC_HDR;
                  if (hdr_a == scfp_pkg::POWER_DOWN_CODE) begin
                    pend_pd_nxt = 1'b1;
                  end else if (hdr_a == scfp_pkg::OSC_OFF_CODE) begin
                    pend_xo_nxt = 1'b1;
                  end else begin
                    stb_v_nxt = 1'b1;
                    stb_c_nxt = hdr_a;
                    flush     = flush |
                                (hdr_a == scfp_pkg::FLUSH_TX_CODE);
                  end
                end else begin
                  dec_nxt = scfp_pkg::DEC_HDR;
                end
              end else if (hdr_rw) begin
                dec_nxt      = scfp_pkg::DEC_RD;
                cfg_addr_nxt = hdr_a;
                cfg_re_nxt   = 1'b1;
              end else begin
                dec_nxt = scfp_pkg::DEC_WR;
              end
            end
            scfp_pkg::DEC_WR: begin
              cfg_addr_nxt  = addr_r;
              cfg_wdata_nxt = byte_in;
              cfg_we_nxt    = 1'b1;
              if (burst_r) begin
                addr_nxt = addr_r + 6'h01;
              end else begin
                dec_nxt = scfp_pkg::DEC_HDR;
              end
            end
            scfp_pkg::DEC_RD: begin
              if (burst_r) begin
                addr_nxt     = addr_r + 6'h01;
                cfg_addr_nxt = addr_r + 6'h01;
                cfg_re_nxt   = 1'b1;
              end else begin
                dec_nxt = scfp_pkg::DEC_HDR;
              end
            end
            scfp_pkg::DEC_FIFO: begin
              // A byte sent to a full queue is lost
              push = (cnt_r != DEPTH_C);
              if (!burst_r) begin
                dec_nxt = scfp_pkg::DEC_HDR;
              end
            end
            default: begin
              dec_nxt = scfp_pkg::DEC_HDR;
            end
          endcase
        end
      end
    end
    so_nxt = out_nxt[7];
    // Underrun raised by the radio wins over a flush in the same cycle
    under_nxt = underflow_i | (under_r & ~flush);
    wptr_nxt  = wptr_r + PTR_W'(push);
    rptr_nxt  = rptr_r + PTR_W'(pop);
    cnt_nxt   = cnt_r + CNT_W'(push) - CNT_W'(pop);
    if (flush) begin
      wptr_nxt = '0;
      rptr_nxt = '0;
      cnt_nxt  = '0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      dec_r       <= scfp_pkg::DEC_HDR;
      sclk_d_r    <= 1'b0;
      csn_d_r     <= 1'b1;
      addr_r      <= '0;
      burst_r     <= 1'b0;
      bit_r       <= '0;
      in_r        <= '0;
      out_r       <= '0;
      load_r      <= 1'b0;
      first_r     <= 1'b1;
      so_r        <= 1'b0;
      oe_r        <= 1'b0;
      cfg_addr_r  <= '0;
      cfg_wdata_r <= '0;
      cfg_we_r    <= 1'b0;
      cfg_re_r    <= 1'b0;
      stb_v_r     <= 1'b0;
      stb_c_r     <= '0;
      pend_pd_r   <= 1'b0;
      pend_xo_r   <= 1'b0;
      under_r     <= 1'b0;
      wptr_r      <= '0;
      rptr_r      <= '0;
      cnt_r       <= '0;
    end else begin
      dec_r       <= dec_nxt;
      sclk_d_r    <= sclk_s;
      csn_d_r     <= csn_s;
      addr_r      <= addr_nxt;
      burst_r     <= burst_nxt;
      bit_r       <= bit_nxt;
      in_r        <= in_nxt;
      out_r       <= out_nxt;
      load_r      <= load_nxt;
      first_r     <= first_nxt;
      so_r        <= so_nxt;
      oe_r        <= oe_nxt;
      cfg_addr_r  <= cfg_addr_nxt;
      cfg_wdata_r <= cfg_wdata_nxt;
      cfg_we_r    <= cfg_we_nxt;
      cfg_re_r    <= cfg_re_nxt;
      stb_v_r     <= stb_v_nxt;
      stb_c_r     <= stb_c_nxt;
      pend_pd_r   <= pend_pd_nxt;
      pend_xo_r   <= pend_xo_nxt;
      under_r     <= under_nxt;
      wptr_r      <= wptr_nxt;
      rptr_r      <= rptr_nxt;
      cnt_r       <= cnt_nxt;
    end
  end

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wptr_r] <= byte_in;
    end
  end

  // ----------------------------------------------------------------
  // Output buffer toward the radio
  // ----------------------------------------------------------------
  scfp_skid #(
    .W (8)
  ) u_skid (
    .clock_i     (clock_i),
    // A flush also drops the words already waiting in the buffer
    .srst_i      (srst_i | flush),
    .in_valid_i  (cnt_r != '0),
    .in_data_i   (mem[rptr_r]),
    .in_ready_o  (skid_ready),
    .out_valid_o (tx_valid_o),
    .out_data_o  (tx_data_o),
    .out_ready_i (tx_ready_i)
  );

  assign serial_out_o    = so_r;
  assign serial_out_oe_o = oe_r;
  assign cfg_addr_o      = cfg_addr_r;
  assign cfg_wdata_o     = cfg_wdata_r;
  assign cfg_we_o        = cfg_we_r;
  assign cfg_re_o        = cfg_re_r;
  assign strobe_valid_o  = stb_v_r;
  assign strobe_code_o   = stb_c_r;

endmodule

// ===== tb/scfp_port_monitor.sv
// Purpose: Concurrent checks on the serial port's pins and outputs.
// Assumes: One clock domain, synchronous reset.
// Notes:   Sees only top-level ports.
`timescale 1ns/1ns
module scfp_port_monitor (
  // Clock and reset
  input wire logic       clock_i,
  input wire logic       srst_i,
  // Serial pins
  input wire logic       sclk_i,
  input wire logic       chip_select_low_i,
  input wire logic       serial_out_o,
  input wire logic       serial_out_oe_o,
  input wire logic       osc_stable_i,
  // Core side
  input wire logic [5:0] cfg_addr_o,
  input wire logic       cfg_we_o,
  input wire logic       strobe_valid_o,
  input wire logic [5:0] strobe_code_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);

  a_oe_on_select: assert property (
    $fell(chip_select_low_i) |-> ##[1:4] serial_out_oe_o)
    else $error("oe not raised after select");
  a_oe_off_deselect: assert property (
    chip_select_low_i [*5] |-> !serial_out_oe_o)
    else $error("oe still high after deselect");
  a_ready_bit_tracks: assert property (
    $fell(chip_select_low_i) ##1
    (!chip_select_low_i && !sclk_i && $stable(osc_stable_i)) [*5]
    |-> serial_out_o == !osc_stable_i)
    else $error("ready bit wrong before first link clock");
  a_write_target: assert property (
    cfg_we_o |-> cfg_addr_o < 6'h30 || cfg_addr_o == 6'h3E)
    else $error("register write at strobe or queue address");
  a_write_single: assert property (
    cfg_we_o |=> !cfg_we_o)
    else $error("write pulse longer than one cycle");
  a_strobe_range: assert property (
    strobe_valid_o |-> strobe_code_o inside {[6'h30:6'h3D]})
    else $error("strobe code out of range");
  a_strobe_deferred: assert property (
    strobe_valid_o && strobe_code_o inside {6'h32, 6'h39}
    |-> $past(chip_select_low_i, 2))
    else $error("deferred strobe ran while selected");
  a_strobe_single: assert property (
    strobe_valid_o && strobe_code_o != 6'h39 |=> !strobe_valid_o)
    else $error("strobe pulse repeated");
endmodule

// ===== tb/scfp_host.sv
// Purpose: Serial bus master model for the port's link pins.
// Assumes: Link clock idles low; data changes while it is low.
// Notes:   A released data line shows the inverse of its last bit.
`timescale 1ns/1ns
module scfp_host (
  // Clock
  input  wire logic clock_i,
  // Link pins
  input  wire logic miso_i,
  output logic      sclk_o,
  output logic      mosi_o,
  output logic      csn_o
);
  int to_cnt = 0;
  initial begin
    sclk_o = 1'b0;
    mosi_o = 1'b0;
    csn_o  = 1'b1;
  end
  // Hold the clock back until the port pulls its output low
  task automatic sel();
    int n;
    n = 0;
    csn_o = 1'b0;
    repeat (4) @(posedge clock_i);
    while (miso_i !== 1'b0 && n < 40) begin
      @(posedge clock_i);
      n++;
    end
    #1;
    if (n == 40) to_cnt++;
  endtask
  task automatic desel();
    csn_o = 1'b1;
    mosi_o = ~mosi_o;
    repeat (8) @(posedge clock_i);
    #1;
  endtask
  // Shift n bits of one byte; a short count aborts mid-byte
  task automatic xfer(input logic [7:0] tx, input int n,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      mosi_o = tx[i];
      #400 sclk_o = 1'b1;
      rx[i] = miso_i;
      #400 sclk_o = 1'b0;
    end
  endtask
endmodule

// ===== tb/scfp_port_tb.sv
// Purpose: Self-checking bench for the serial configuration port.
// Assumes: Queue depth cut to 16 so fill and drain stay short.
// Notes:   Two queued bytes sit in the output buffer, not the count.
`timescale 1ns/1ns
module scfp_port_tb;
  localparam int DEPTH = 16;
  logic       clock_i, srst_i, sclk_i, serial_in_i, chip_select_low_i;
  logic       serial_out_o, serial_out_oe_o, osc_stable_i, underflow_i;
  logic       sleep_enter_i, cfg_we_o, cfg_re_o, strobe_valid_o;
  logic       tx_valid_o, tx_ready_i, miso;
  logic [2:0] main_state_i;
  logic [5:0] cfg_addr_o, strobe_code_o, wa, sc, ra;
  logic [7:0] cfg_wdata_o, cfg_rdata_i, tx_data_o, wd, st, e;
  logic [7:0] rxq[$];
  int         failures, n_compared, nst;

  scfp_port #(.DEPTH(DEPTH)) uut (.*);
  scfp_host host (.clock_i(clock_i), .miso_i(miso), .sclk_o(sclk_i),
                  .mosi_o(serial_in_i), .csn_o(chip_select_low_i));
  assign miso = serial_out_oe_o ? serial_out_o : ~serial_out_o;
  // Register file model: read data is the inverse of the address read
  assign cfg_rdata_i = ~{2'h0, ra};
  always #50 clock_i = ~clock_i;

  always @(posedge clock_i) begin
    if (cfg_we_o === 1'b1) {wa, wd} <= {cfg_addr_o, cfg_wdata_o};
    if (cfg_re_o === 1'b1) ra <= cfg_addr_o;
    if (strobe_valid_o === 1'b1) begin
      sc <= strobe_code_o;
      nst <= nst + 1;
    end
    if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) rxq.push_back(tx_data_o);
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (failures == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic s();
    host.sel();
    if (host.to_cnt != 0) begin
      failures++;
      final_report();
    end
  endtask
  task automatic b(input logic [7:0] t);
    host.xfer(t, 8, st);
  endtask
  task automatic pulse(ref logic x);
    x = 1'b1;
    @(posedge clock_i);
    #1 x = 1'b0;
  endtask

  task automatic sc_osc();
    osc_stable_i = 1'b0;
    fork
      s();
      begin
        repeat (10) @(posedge clock_i);
        #1 chk(serial_out_o, 1'b1);
        osc_stable_i = 1'b1;
      end
    join
    b(8'h80);
    chk(st[7], 1'b0);
    b(8'h00);
    host.desel();
  endtask
  task automatic sc_write();
    s();
    b(8'h05);
    chk(st, 8'h0F);
    b(8'hAA);
    chk(st, 8'h0F);
    chk({2'h0, wa, wd}, 16'h05AA);
    b(8'h50);
    b(8'h11);
    chk({2'h0, wa, wd}, 16'h1011);
    b(8'h22);
    host.desel();
    chk({2'h0, wa, wd}, 16'h1122);
    s();
    b(8'h87);
    b(8'h00);
    chk(st, 8'hF8);
    b(8'hF5);
    b(8'h00);
    chk(st, 8'hCA);
    host.desel();
  endtask
  task automatic sc_strobes();
    s();
    b(8'h3B);
    b(8'h3F);
    chk(sc, 8'h3B);
    b(8'h99);
    b(8'h05);
    b(8'h66);
    e = 8'(nst);
    b(8'h39);
    b(8'h32);
    repeat (10) @(posedge clock_i);
    chk({2'h0, wa, wd}, 16'h0566);
    chk(8'(nst) - e, 8'h00);
    host.desel();
    chk({8'(nst) - e, 2'h0, sc}, 16'h0232);
    s();
    host.xfer(8'h3F, 5, st);
    host.desel();
    s();
    b(8'h05);
    b(8'h77);
    host.desel();
    chk({2'h0, wa, wd}, 16'h0577);
  endtask
  task automatic sc_underrun();
    pulse(underflow_i);
    s();
    b(8'h80);
    chk(st[7:4], 4'h7);
    b(8'h00);
    main_state_i = 3'h2;
    b(8'h3B);
    b(8'h80);
    chk(st[7:4], 4'h2);
    b(8'h00);
    host.desel();
  endtask
  task automatic sc_sleep_fill();
    tx_ready_i = 1'b0;
    s();
    b(8'h7F);
    for (int k = 0; k < 5; k++) b(8'h00);
    host.desel();
    // Receiver stays stalled so only the sleep flush can free the queue
    pulse(sleep_enter_i);
    s();
    b(8'h3B);
    chk(st[3:0], 4'hF);
    b(8'h7F);
    for (int k = 0; k < DEPTH + 3; k++) begin
      b(8'h40 + 8'(k));
      e = 8'(DEPTH - (k < 2 ? 0 : k - 2));
      chk(st[3:0], e > 8'h0F ? 4'hF : e[3:0]);
    end
    host.desel();
    rxq.delete();
    for (int n = 0; n < 400 && rxq.size() < DEPTH + 2; n++) begin
      @(posedge clock_i);
      #1 tx_ready_i = ~tx_ready_i;
    end
    tx_ready_i = 1'b1;
    repeat (8) @(posedge clock_i);
    chk(16'(rxq.size()), 16'(DEPTH + 2));
    if (rxq.size() != DEPTH + 2) final_report();
    foreach (rxq[i]) chk(rxq[i], 8'h40 + 8'(i));
  endtask

  initial begin
    clock_i = 1'b0;
    srst_i = 1'b1;
    failures = 0;
    n_compared = 0;
    nst = 0;
    osc_stable_i = 1'b1;
    main_state_i = 3'h0;
    underflow_i = 1'b0;
    sleep_enter_i = 1'b0;
    tx_ready_i = 1'b1;
    repeat (8) @(posedge clock_i);
    #1 srst_i = 1'b0;
    repeat (4) @(posedge clock_i);
    #1;
    sc_osc();
    sc_write();
    sc_strobes();
    sc_underrun();
    sc_sleep_fill();
    final_report();
  end
endmodule

bind scfp_port scfp_port_monitor mon (.*);
